// File: core/umc_modem_line_control.sv
// Operation
// R1: Bit7 selects clock divide by one or four
// R2: Bit6 selects normal or infrared encoding
// R3: Bit5 enables any-character resume
// R4: Bit4 loops transmit back to receive
// R5: Loopback feeds low control bits into status
// R6: Bit2 enables trigger register access
// R7: Bit1 drives request-to-send, active low
// R8: Loopback request-to-send sets status bit four
// R9: Auto flow control overrides request-to-send bit
// R10: Bit0 drives terminal-ready on assigned pin
// R11: Pin-state writes ignored on terminal-ready pin
// R12: Protected bits write only when enable set
// R13: Bit3 reserved, reads zero
module umc_modem_line_control (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       regWrite,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic [7:0] enhancedFeatureReg,
  input  wire logic [7:0] pinFunctionControl,
  input  wire logic [7:0] pinStateWrite,
  input  wire logic       autoRtsEn,
  input  wire logic       autoRtsLevelN,
  input  wire logic       txSerial,
  input  wire logic       rxPin,
  input  wire logic       ctsPinN,
  input  wire logic       dsrPinN,
  output logic            rtsPinN,
  output logic            generalPinFive,
  output logic            generalPinOne,
  output logic            rxToCore,
  output logic            baudClkEn,
  output logic            irModeEn,
  output logic            anyResumeEn,
  output logic            trigRegAccessEn,
  output logic            loopbackEn,
  output logic      [1:0] statusLines
);

  // ----------------------------------------------------------------
  // Input synchronisers for pins
  // ----------------------------------------------------------------
  logic [2:0] pinMeta_q;
  logic [2:0] pinSync_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pinMeta_q <= 3'h7;
      pinSync_q <= 3'h7;
    end else begin
      pinMeta_q <= {dsrPinN, ctsPinN, rxPin};
      pinSync_q <= pinMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] wrMask;
  always_comb begin
    wrMask = ~umc_pkg::ResvMask;                                  // R13
    if (!enhancedFeatureReg[umc_pkg::EfrWeBit]) begin
      wrMask = wrMask & ~umc_pkg::ProtMask;                        // R12
    end
    ctrl_d = ctrl_q;
    if (regWrite) begin
      ctrl_d = (regWdata & wrMask) | (ctrl_q & ~wrMask);
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_q <= umc_pkg::ResetVal;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic [1:0] div_q;
  logic [1:0] div_d;
  logic       baud_d;
  // The counter end and the slow ratio must agree, or the slow baud tick drifts
  if (umc_pkg::DivSlow != int'(umc_pkg::DivLast) + 1) begin : g_divCheck
    $error("prescaler counter end does not match the slow ratio");
  end
  always_comb begin
    div_d  = div_q + 2'h1;
    baud_d = 1'b1;                                                // R1
    if (ctrl_q[umc_pkg::ClkDivBit]) begin
      baud_d = (div_q == umc_pkg::DivLast);                       // R1
    end
  end

  // ----------------------------------------------------------------
  // Output side
  // ----------------------------------------------------------------
  logic       dtrAssigned;
  logic       rts_d;
  logic       pin5_d;
  logic       pin1_d;
  logic       rx_d;
  logic [1:0] stat_d;
  logic       loopOn;
  always_comb begin
    loopOn      = ctrl_q[umc_pkg::LoopBit];
    dtrAssigned = pinFunctionControl[umc_pkg::PinFnBit1] | pinFunctionControl[umc_pkg::PinFnBit2];
    rts_d = ~ctrl_q[umc_pkg::RtsBit];                             // R7
    if (autoRtsEn) begin
      rts_d = autoRtsLevelN;                                      // R9
    end
    pin5_d = pinStateWrite[umc_pkg::PinFive];
    pin1_d = pinStateWrite[umc_pkg::PinOne];
    if (dtrAssigned) begin
      pin5_d = ~ctrl_q[umc_pkg::DtrBit];                          // R10 R11
      pin1_d = ~ctrl_q[umc_pkg::DtrBit];                          // R10 R11
    end
    rx_d   = pinSync_q[0];
    stat_d = ~pinSync_q[2:1];
    if (loopOn) begin
      rx_d   = txSerial;                                          // R4
      stat_d = {ctrl_q[umc_pkg::DtrBit], ctrl_q[umc_pkg::RtsBit]}; // R5 R8
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_q           <= 2'h0;
      baudClkEn       <= 1'b0;
      regRdata        <= umc_pkg::ResetVal;
      rtsPinN         <= 1'b1;
      generalPinFive  <= 1'b1;
      generalPinOne   <= 1'b1;
      rxToCore        <= 1'b1;
      statusLines     <= 2'h0;
      irModeEn        <= 1'b0;
      anyResumeEn     <= 1'b0;
      trigRegAccessEn <= 1'b0;
      loopbackEn      <= 1'b0;
    end else begin
      div_q           <= div_d;
      baudClkEn       <= baud_d;
      regRdata        <= ctrl_d & ~umc_pkg::ResvMask;             // R13
      rtsPinN         <= rts_d;
      generalPinFive  <= pin5_d;
      generalPinOne   <= pin1_d;
      rxToCore        <= rx_d;
      statusLines     <= stat_d;
      irModeEn        <= ctrl_d[umc_pkg::IrModeBit];              // R2
      anyResumeEn     <= ctrl_d[umc_pkg::AnyResumeBit];           // R3
      trigRegAccessEn <= ctrl_d[umc_pkg::TrigEnBit];              // R6
      loopbackEn      <= ctrl_d[umc_pkg::LoopBit];                // R4
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_r12;
    @(posedge mclk) disable iff (reset)
      regWrite && !enhancedFeatureReg[umc_pkg::EfrWeBit] |=>
        (regRdata & umc_pkg::ProtMask) == ($past(regRdata) & umc_pkg::ProtMask);
  endproperty
  a_r12: assert property (p_r12) else $error("protected bits changed"); // R12

  property p_r13;
    @(posedge mclk) disable iff (reset) regRdata[3] == 1'b0;
  endproperty
  a_r13: assert property (p_r13) else $error("reserved bit set"); // R13

  property p_r1;
    @(posedge mclk) disable iff (reset) !ctrl_q[7] |=> baudClkEn;
  endproperty
  a_r1: assert property (p_r1) else $error("undivided clock enable missing"); // R1

  property p_r7;
    @(posedge mclk) disable iff (reset) !autoRtsEn |=> rtsPinN == !$past(ctrl_q[1]);
  endproperty
  a_r7: assert property (p_r7) else $error("rts level wrong"); // R7

  property p_r9;
    @(posedge mclk) disable iff (reset) autoRtsEn |=> rtsPinN == $past(autoRtsLevelN);
  endproperty
  a_r9: assert property (p_r9) else $error("auto rts not followed"); // R9

  property p_r8;
    @(posedge mclk) disable iff (reset) ctrl_q[4] |=> statusLines[0] == $past(ctrl_q[1]);
  endproperty
  a_r8: assert property (p_r8) else $error("loopback status wrong"); // R8

  property p_r4;
    @(posedge mclk) disable iff (reset) ctrl_q[4] |=> rxToCore == $past(txSerial);
  endproperty
  a_r4: assert property (p_r4) else $error("loopback rx wrong"); // R4

  property p_r10;
    @(posedge mclk) disable iff (reset)
      (pinFunctionControl[1] | pinFunctionControl[2]) |=> generalPinFive == !$past(ctrl_q[0]);
  endproperty
  a_r10: assert property (p_r10) else $error("dtr pin wrong"); // R10

  property p_r11;
    @(posedge mclk) disable iff (reset)
      (pinFunctionControl[umc_pkg::PinFnBit1] | pinFunctionControl[umc_pkg::PinFnBit2]) |=>
        generalPinOne == !$past(ctrl_q[umc_pkg::DtrBit]);
  endproperty
  a_r11: assert property (p_r11) else $error("terminal-ready pin one wrong"); // R11

  property p_r5;
    @(posedge mclk) disable iff (reset)
      ctrl_q[umc_pkg::LoopBit] |=> statusLines[1] == $past(ctrl_q[umc_pkg::DtrBit]);
  endproperty
  a_r5: assert property (p_r5) else $error("loopback terminal-ready status wrong"); // R5

  // Unlocked writes must reach the mode outputs at the write edge
  property p_r2;
    @(posedge mclk) disable iff (reset)
      regWrite && enhancedFeatureReg[umc_pkg::EfrWeBit] |=> irModeEn == $past(regWdata[umc_pkg::IrModeBit]);
  endproperty
  a_r2: assert property (p_r2) else $error("infrared mode not taken"); // R2

  property p_r3;
    @(posedge mclk) disable iff (reset)
      regWrite && enhancedFeatureReg[umc_pkg::EfrWeBit] |=>
        anyResumeEn == $past(regWdata[umc_pkg::AnyResumeBit]);
  endproperty
  a_r3: assert property (p_r3) else $error("any-character resume not taken"); // R3

  property p_r6;
    @(posedge mclk) disable iff (reset)
      regWrite && enhancedFeatureReg[umc_pkg::EfrWeBit] |=>
        trigRegAccessEn == $past(regWdata[umc_pkg::TrigEnBit]);
  endproperty
  a_r6: assert property (p_r6) else $error("trigger access enable not taken"); // R6

  c_loop:  cover property (@(posedge mclk) disable iff (reset) loopbackEn);
  c_div4:  cover property (@(posedge mclk) disable iff (reset) ctrl_q[7] ##1 !baudClkEn);
  c_block: cover property (@(posedge mclk) disable iff (reset) regWrite && !enhancedFeatureReg[4]);
  c_dtr:   cover property (@(posedge mclk) disable iff (reset) (pinFunctionControl[2:1] != 2'h0) && ctrl_q[0]);
endmodule

// File: include/umc_pkg.sv
package umc_pkg;
  // ----------------------------------------------------------------
  // Modem line control field positions
  // ----------------------------------------------------------------
  localparam int unsigned ClkDivBit    = 7;
  localparam int unsigned IrModeBit    = 6;
  localparam int unsigned AnyResumeBit = 5;
  localparam int unsigned LoopBit      = 4;
  localparam int unsigned ResvBit      = 3;
  localparam int unsigned TrigEnBit    = 2;
  localparam int unsigned RtsBit       = 1;
  localparam int unsigned DtrBit       = 0;
  localparam int unsigned EfrWeBit     = 4;
  // Bits that need the enhanced write enable
  localparam logic [7:0]  ProtMask     = 8'he4;
  // Bits that never store
  localparam logic [7:0]  ResvMask     = 8'h08;
  localparam logic [7:0]  ResetVal     = 8'h00;
  // Prescaler ratios
  localparam int unsigned DivSlow      = 4;
  localparam logic [1:0]  DivLast      = 2'h3;
  // Modem status positions fed in loopback
  localparam int unsigned StatCtsBit   = 4;
  localparam int unsigned StatDsrBit   = 5;
  // Pin function select and pin-state positions for terminal-ready routing
  localparam int unsigned PinFnBit1    = 1;
  localparam int unsigned PinFnBit2    = 2;
  localparam int unsigned PinFive      = 5;
  localparam int unsigned PinOne       = 1;
endpackage

// File: sim/umc_modem_peer.sv
// Modem side: drives the serial receive line and the two status inputs.
// The pins are driven only on the falling edge so that the design's
// synchroniser never samples a value that is still changing.
module umc_modem_peer (
  input  wire logic       mclk,
  input  wire logic [2:0] lineSet,
  output logic            rxPin,
  output logic            ctsPinN,
  output logic            dsrPinN
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {rxPin, dsrPinN, ctsPinN} = 3'h7;
  always @(negedge mclk) begin
    {rxPin, dsrPinN, ctsPinN} <= lineSet;
  end
endmodule

// File: sim/umc_modem_line_control_tb.sv
module umc_modem_line_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk = 0, reset = 1, regWrite = 0, autoRtsEn = 0, autoRtsLevelN = 1, txSerial = 1;
  logic [7:0] regWdata = 0, enhanced_feature_reg = 0, pinFn = 0, pinSt = 0, regRdata, model;
  logic [2:0] lines = 3'h7;
  logic [1:0] statusLines;
  logic       rxPin, ctsPinN, dsrPinN, rtsPinN, gp5, gp1, rxToCore, baudClkEn;
  logic       irModeEn, anyResumeEn, trigRegAccessEn, loopbackEn;
  int         mismatches = 0, samples_checked = 0, cnt;
  always #5 mclk = ~mclk;
  umc_modem_peer i_umc_modem_peer (.mclk(mclk), .lineSet(lines), .rxPin(rxPin), .ctsPinN(ctsPinN),
    .dsrPinN(dsrPinN));
  umc_modem_line_control i_umc_modem_line_control (.mclk(mclk), .reset(reset), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .enhancedFeatureReg(enhanced_feature_reg), .pinFunctionControl(pinFn),
    .pinStateWrite(pinSt), .autoRtsEn(autoRtsEn), .autoRtsLevelN(autoRtsLevelN), .txSerial(txSerial),
    .rxPin(rxPin), .ctsPinN(ctsPinN), .dsrPinN(dsrPinN), .rtsPinN(rtsPinN), .generalPinFive(gp5),
    .generalPinOne(gp1), .rxToCore(rxToCore), .baudClkEn(baudClkEn), .irModeEn(irModeEn),
    .anyResumeEn(anyResumeEn), .trigRegAccessEn(trigRegAccessEn), .loopbackEn(loopbackEn),
    .statusLines(statusLines));
  // Protected bits keep their old value unless the enhanced write enable is set
  function automatic logic [7:0] nextReg(input logic [7:0] old, input logic [7:0] wd, input logic we);
    return (we ? wd : ((wd & ~umc_pkg::ProtMask) | (old & umc_pkg::ProtMask))) & ~umc_pkg::ResvMask;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Leaves regWrite high so that two calls in a row are back to back
  task automatic wr(input logic [7:0] d);
    @(negedge mclk);
    regWrite = 1;
    regWdata = d;
    model    = nextReg(model, d, enhanced_feature_reg[umc_pkg::EfrWeBit]);
  endtask
  task automatic settle();
    @(negedge mclk);
    regWrite = 0;
    chk(regRdata, model);
    chk(irModeEn, model[6]);
    chk(anyResumeEn, model[5]);
    chk(loopbackEn, model[4]);
    chk(trigRegAccessEn, model[2]);
    repeat (3) @(negedge mclk);
    chk(rtsPinN, {autoRtsEn ? autoRtsLevelN : ~model[1]});
    chk(statusLines, {model[4] ? {model[0], model[1]} : ~lines[1:0]});
    chk(rxToCore, model[4] ? txSerial : lines[2]);
    chk(gp5, {(pinFn[2:1] != 2'h0) ? ~model[0] : pinSt[5]});
    chk(gp1, {(pinFn[2:1] != 2'h0) ? ~model[0] : pinSt[1]});
    cnt = 0;
    repeat (8) @(negedge mclk) cnt += baudClkEn;
    chk(cnt[7:0], model[7] ? 8'h02 : 8'h08);
  endtask
  task automatic doReset();
    @(negedge mclk);
    reset    = 1;
    regWrite = 0;
    repeat (2) @(negedge mclk);
    reset = 0;
    model = umc_pkg::ResetVal;
    chk(regRdata, umc_pkg::ResetVal);
    chk(rtsPinN, 1'b1);
    chk(rxToCore, 1'b1);
    $display("test reset done");
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(99));
    doReset();
    // Locked writes, then unlocked, then clear
    enhanced_feature_reg = 8'h00;
    wr(8'hff);
    settle();
    enhanced_feature_reg = 8'h10;
    wr(8'hff);
    settle();
    wr(8'h00);
    settle();
    $display("test corners done");
    for (int i = 0; i < 60; i++) begin
      enhanced_feature_reg           = $urandom;
      autoRtsEn     = $urandom;
      autoRtsLevelN = $urandom;
      txSerial      = $urandom;
      lines         = $urandom;
      pinSt         = $urandom;
      pinFn         = 8'($urandom_range(3) << 1);
      wr($urandom);
      if ($urandom_range(1)) wr($urandom);
      settle();
    end
    $display("test random done");
    wr(8'h13);
    doReset();
    settle();
    close_out();
  end
endmodule
